// [inc/lsfs_pkg.sv]
// constants, field positions and state encoding of the start-up/fault sequencer
// assumes a single 10 MHz clock that is also the boost switching clock
package lsfs_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int NCH = 4;

    // detect delay window, in switching cycles; the chosen wait sits inside it
    localparam int DETECT_MIN_CYC = 3000;
    localparam int DETECT_MAX_CYC = 4000;
    localparam int DETECT_CYC = (DETECT_MIN_CYC + DETECT_MAX_CYC) / 2;

    // defaults of the long counts, in switching cycles
    localparam int MOD_OC_CYC_DEF = 10000;
    localparam int ENLOW_CYC_DEF = 32750;

    // severe overcurrent must shut down within this time (longest time: round down)
    localparam int SEVERE_OC_MAX_NS = 3000;
    localparam int SEVERE_OC_MAX_CYC = SEVERE_OC_MAX_NS / CLK_PERIOD_NS;

    // host side: first enable pulse length (least time: round up)
    localparam int FIRST_EN_MIN_NS = 750;
    localparam int FIRST_EN_MIN_CYC = (FIRST_EN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] EVENT_OFF = 12'h008;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [3:0] EVENT_RST = 4'h0;

    // field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_USED_LSB = 8;
    localparam int ST_SHORT_LSB = 12;
    localparam int EV_MOD_OC = 0;
    localparam int EV_SEV_OC = 1;
    localparam int EV_EN_LOW = 2;
    localparam int EV_UV_DROP = 3;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_GATE = 6'h02,
        S_DETECT = 6'h04,
        S_SHORT = 6'h08,
        S_SOFT = 6'h10,
        S_RUN = 6'h20
    } lsfs_state_t;

endpackage : lsfs_pkg

// [design/lsfs_sync2.sv]
// two-flop synchroniser for a vector of independent pin levels
// assumes each bit is a slow level; no bus coherency between bits is promised
`timescale 1ns/10ps
module lsfs_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule : lsfs_sync2

// [design/lsfs_ocp.sv]
// input overcurrent qualifier: persistent moderate trip and instant severe trip
// assumes synchronised comparator levels and an arm level from the sequencer
`timescale 1ns/10ps
module lsfs_ocp
    import lsfs_pkg::*;
#(
    parameter int MOD_OC_CYC = MOD_OC_CYC_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic armed,
    input wire logic trip1,
    input wire logic trip2,
    output logic modTrip,
    output logic sevTrip
);

    logic [13:0] modCnt_ff;
    logic modTrip_ff;
    logic sevTrip_ff;
    wire modLevel = armed && trip1 && !trip2;
    wire modDone = modLevel && (modCnt_ff == 14'(MOD_OC_CYC - 1));

    // counter restarts whenever the condition lapses: only a persistent overload trips
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modCnt_ff <= '0;
            modTrip_ff <= 1'b0;
            sevTrip_ff <= 1'b0;
        end else begin
            modCnt_ff <= (modLevel && !modDone) ? modCnt_ff + 14'h0001 : 14'h0000;
            modTrip_ff <= modDone;
            sevTrip_ff <= armed && trip2;
        end
    end

    assign modTrip = modTrip_ff;
    assign sevTrip = sevTrip_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence modHeld_s;
        modLevel [*8];
    endsequence

    mod_needs_hold_a: assert property ($rose(modTrip_ff) |-> $past(modLevel))
        else $error("moderate trip without the overload level");
    mod_count_a: assert property (modDone |-> modCnt_ff == 14'(MOD_OC_CYC - 1))
        else $error("moderate trip before full persistence count");
    mod_no_early_a: assert property (modHeld_s and (modCnt_ff < 14'h0008)[*1]
        |=> !modTrip_ff || (MOD_OC_CYC <= 9))
        else $error("moderate trip after only a few cycles");
    sev_fast_a: assert property ((armed && trip2) |=> sevTrip_ff)
        else $error("severe trip not flagged next cycle");

endmodule : lsfs_ocp

// [design/lsfs_sequencer.sv]
// start-up and fault sequencer of a four-channel LED boost driver, APB slave
// assumes analog comparator levels on pins (synchronised here) and clk = fsw
//
// Behaviour
// - start needs enable high and supply above rise
// - frequency pin held low blocks power-up
// - system check passes before any sink on
// - disconnect drive first, then channel check
// - detect waits for gate at level
// - wait 3000..4000 cycles after detect threshold
// - classify channel short, unused, or in use
// - unused channel off and out of loop
// - short holds off soft start, then recheck
// - moderate overcurrent shuts down after persistence
// - severe overcurrent shuts down at once
// - after start, run until lower supply level
// - enable low too long enters shutdown
// - soft start: reduced sink and switch limit
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module lsfs_sequencer
    import lsfs_pkg::*;
#(
    parameter int MOD_OC_CYC = MOD_OC_CYC_DEF,
    parameter int ENLOW_CYC = ENLOW_CYC_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enablePin,
    input wire logic uvloRiseOk,
    input wire logic uvloRunOk,
    input wire logic freqSetSyncLow,
    input wire logic gateAtLevel,
    input wire logic [3:0] ledAboveDetect,
    input wire logic [3:0] ledShortGnd,
    input wire logic [3:0] ledInUse,
    input wire logic ledHeadroomOk,
    input wire logic senseTrip1,
    input wire logic senseTrip2,
    output logic disconnectDrive,
    output logic [3:0] sinkEnable,
    output logic [3:0] loopInclude,
    output logic softStartMode,
    output logic switchLimitLow
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [19:0] pinSync;
    logic enS, uvRiseS, uvRunS, fsetLowS, gateS, headS, trip1S, trip2S;
    logic [3:0] aboveS, shortS, inUseS;

    lsfs_sync2 #(.W(20)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .din({enablePin, uvloRiseOk, uvloRunOk, freqSetSyncLow, gateAtLevel,
              ledAboveDetect, ledShortGnd, ledInUse, ledHeadroomOk, senseTrip1, senseTrip2}),
        .dout(pinSync)
    );

    assign {enS, uvRiseS, uvRunS, fsetLowS, gateS, aboveS, shortS, inUseS,
            headS, trip1S, trip2S} = pinSync;

    ////////////////////////////////////////////////////////////////////////////
    // overcurrent qualification

    lsfs_state_t state_ff, nxt_state;
    logic modTrip, sevTrip;
    wire ocTrip = modTrip || sevTrip;

    lsfs_ocp #(.MOD_OC_CYC(MOD_OC_CYC)) u_ocp (
        .clk(clk),
        .rstn(rstn),
        .armed(state_ff != S_IDLE),
        .trip1(trip1S),
        .trip2(trip2S),
        .modTrip(modTrip),
        .sevTrip(sevTrip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, unmapped offsets answer with pslverr

    function automatic logic regHit(input logic [11:0] addr, input logic [11:0] off);
        regHit = (addr == off);
    endfunction : regHit

    logic [31:0] ctrl_ff;
    logic [3:0] events_ff, nxt_events;
    logic [3:0] used_ff, shortSeen_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;

    wire setupPh = psel && !penable;
    wire wrDone = psel && penable && pready_ff && pwrite;
    wire hitCtrl = regHit(paddr, CTRL_OFF);
    wire hitStat = regHit(paddr, STATUS_OFF);
    wire hitEvt = regHit(paddr, EVENT_OFF);
    wire hitAny = hitCtrl || hitStat || hitEvt;
    wire runAllow = ctrl_ff[CTRL_RUN_BIT];

    wire [31:0] statusWord = (32'(state_ff) << ST_STATE_LSB)
                           | (32'(used_ff) << ST_USED_LSB)
                           | (32'(shortSeen_ff) << ST_SHORT_LSB);
    wire [31:0] rdMux = hitCtrl ? ctrl_ff :
                        hitStat ? statusWord :
                        hitEvt ? {28'h0000000, events_ff} : 32'h0000_0000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setupPh;
            pslverr_ff <= setupPh && !hitAny;
            prdata_ff <= (setupPh && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wrDone && hitCtrl) begin
            ctrl_ff <= {31'h00000000, pwdata[CTRL_RUN_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    logic [11:0] detCnt_ff, nxt_detCnt;
    logic [15:0] enLowCnt_ff;
    logic [3:0] nxt_used, nxt_shortSeen;

    // every pin either rose past the detect threshold or is held at ground
    wire settled = &(aboveS | shortS);
    wire detDone = settled && (detCnt_ff == 12'(DETECT_CYC - 1));
    wire startOk = runAllow && enS && uvRiseS && !fsetLowS;
    wire enLowDone = !enS && (enLowCnt_ff == 16'(ENLOW_CYC - 1));
    wire uvDrop = !uvRunS;
    // shutdown causes once the sequence has left idle; supply checked at run level
    wire abortSeq = ocTrip || enLowDone || uvDrop;

    always_comb begin
        nxt_state = state_ff;
        nxt_detCnt = 12'h000;
        nxt_used = used_ff;
        nxt_shortSeen = shortSeen_ff;
        case (state_ff)
            S_IDLE: begin
                if (startOk) begin
                    nxt_state = S_GATE;
                end
            end
            S_GATE: begin
                if (gateS) begin
                    nxt_state = S_DETECT;
                end
            end
            S_DETECT: begin
                // counting restarts if a pin sags back under the threshold
                nxt_detCnt = settled ? detCnt_ff + 12'h001 : 12'h000;
                if (detDone) begin
                    nxt_detCnt = 12'h000;
                    nxt_shortSeen = shortS;
                    nxt_used = inUseS & ~shortS;
                    nxt_state = (|shortS) ? S_SHORT : S_SOFT;
                end
            end
            S_SHORT: begin
                if (!(|shortS)) begin
                    nxt_state = S_DETECT;
                end
            end
            S_SOFT: begin
                if (headS) begin
                    nxt_state = S_RUN;
                end
            end
            S_RUN: begin
                nxt_state = S_RUN;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (state_ff != S_IDLE && abortSeq) begin
            nxt_state = S_IDLE;
            nxt_detCnt = 12'h000;
            nxt_used = 4'h0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= S_IDLE;
            detCnt_ff <= 12'h000;
            used_ff <= 4'h0;
            shortSeen_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            detCnt_ff <= nxt_detCnt;
            used_ff <= nxt_used;
            shortSeen_ff <= nxt_shortSeen;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enLowCnt_ff <= 16'h0000;
        end else if (enS || state_ff == S_IDLE || enLowDone) begin
            enLowCnt_ff <= 16'h0000;
        end else begin
            enLowCnt_ff <= enLowCnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events: sticky, write one to clear, a new event wins over the clear

    wire [3:0] evSet = {uvDrop && state_ff != S_IDLE, enLowDone && state_ff != S_IDLE,
                        sevTrip, modTrip};
    wire [3:0] evClr = (wrDone && hitEvt) ? pwdata[3:0] : 4'h0;

    always_comb begin
        nxt_events = (events_ff & ~evClr) | evSet;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            events_ff <= EVENT_RST;
        end else begin
            events_ff <= nxt_events;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output drive, registered from the next state so it moves with the state

    logic disc_ff, soft_ff;
    logic [3:0] sink_ff, loop_ff;
    wire nxtOn = (nxt_state == S_SOFT) || (nxt_state == S_RUN);
    // dimming: in run the sinks follow the enable pin, soft start keeps them on
    wire [3:0] nxtSink = !nxtOn ? 4'h0 :
                         (nxt_state == S_RUN && !enS) ? 4'h0 : nxt_used;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disc_ff <= 1'b0;
            soft_ff <= 1'b0;
            sink_ff <= 4'h0;
            loop_ff <= 4'h0;
        end else begin
            disc_ff <= (nxt_state != S_IDLE);
            soft_ff <= (nxt_state == S_SOFT);
            sink_ff <= nxtSink;
            loop_ff <= nxtOn ? nxt_used : 4'h0;
        end
    end

    assign disconnectDrive = disc_ff;
    assign softStartMode = soft_ff;
    assign switchLimitLow = soft_ff;
    assign sinkEnable = sink_ff;
    assign loopInclude = loop_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    localparam int SEV_BOUND = 2;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence startCause_s;
        (state_ff == S_IDLE) && startOk;
    endsequence

    // the sampling cycle of the detect phase, then the first cycle of soft start
    sequence sampleToSoft_s;
        (state_ff == S_DETECT) && detDone && !abortSeq ##1 (state_ff == S_SOFT);
    endsequence

    start_cause_a: assert property ($rose(disconnectDrive) |-> $past(startOk))
        else $error("disconnect drive rose without start conditions");
    fset_block_a: assert property ((state_ff == S_IDLE && fsetLowS) |=> state_ff == S_IDLE)
        else $error("left idle while frequency pin low");
    sink_checked_a: assert property ((|sinkEnable) |-> (state_ff == S_SOFT || state_ff == S_RUN)
        && shortSeen_ff == 4'h0)
        else $error("sink on before a passing check");
    gate_first_a: assert property (startCause_s |=> disconnectDrive && state_ff == S_GATE
        ##1 (state_ff != S_DETECT || disconnectDrive))
        else $error("detect entered without disconnect drive");
    gate_level_a: assert property ($rose(state_ff == S_DETECT) && $past(state_ff == S_GATE)
        |-> $past(gateS))
        else $error("detect began before gate reached level");
    detect_wait_a: assert property ((state_ff == S_DETECT) && (nxt_state != S_DETECT) && !abortSeq
        |-> detCnt_ff == 12'(DETECT_CYC - 1) && DETECT_CYC >= DETECT_MIN_CYC
        && DETECT_CYC <= DETECT_MAX_CYC)
        else $error("channel sampled outside the detect window");
    classify_a: assert property (sampleToSoft_s
        |-> used_ff == ($past(inUseS) & ~$past(shortS)))
        else $error("channel class not taken from sampled pins");
    unused_off_a: assert property ((sinkEnable & ~used_ff) == 4'h0 && loopInclude == (
        (state_ff == S_SOFT || state_ff == S_RUN) ? used_ff : 4'h0))
        else $error("unused channel driven or kept in loop");
    short_hold_a: assert property ((state_ff == S_SHORT && (|shortS)) |=>
        (state_ff == S_SHORT || state_ff == S_IDLE))
        else $error("left short hold while a pin is shorted");
    severe_fast_a: assert property ($rose(trip2S) && state_ff != S_IDLE && !ocTrip
        |-> ##[1:SEV_BOUND] state_ff == S_IDLE && !disconnectDrive)
        else $error("severe overcurrent not shut down in time");
    uv_run_a: assert property ((state_ff != S_IDLE) && !uvRunS |=> state_ff == S_IDLE)
        else $error("kept running below run supply level");
    enlow_a: assert property (enLowDone && state_ff != S_IDLE |-> enLowCnt_ff
        == 16'(ENLOW_CYC - 1) ##1 state_ff == S_IDLE)
        else $error("enable-low shutdown at wrong count");
    soft_mode_a: assert property ((state_ff == S_SOFT) |-> softStartMode && switchLimitLow
        && sinkEnable == used_ff)
        else $error("soft start outputs wrong");
    oc_off_a: assert property (ocTrip && state_ff != S_IDLE |=> state_ff == S_IDLE
        && !disconnectDrive && sinkEnable == 4'h0 && events_ff[EV_MOD_OC] | events_ff[EV_SEV_OC])
        else $error("overcurrent did not shut everything off");

endmodule : lsfs_sequencer

// [tb/lsfs_pin_model.sv]
// board and host model: gate and LED pin comparator levels, and the enable pin
// assumes chanCfg holds 2 bits a channel: 0 shorted, 1 unused with pull-down, 2 in use
`timescale 1ns/10ps
module lsfs_pin_model
    import lsfs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hostEn,
    input wire logic [7:0] chanCfg,
    input wire logic [15:0] gateDly,
    input wire logic disconnectDrive,
    input wire logic [3:0] sinkEnable,
    output logic enablePin,
    output logic gateAtLevel,
    output logic [3:0] ledAboveDetect,
    output logic [3:0] ledShortGnd,
    output logic [3:0] ledInUse,
    output logic ledHeadroomOk
);
    int gateCnt;
    int headCnt;
    int enCnt;
    logic hostEnPrev;
    logic pinUp;
    ////////////////////////////////////////////////////////////////////////////////
    // pins float near ground until the supply is connected, so no class shows then
    assign pinUp = disconnectDrive && (gateCnt >= 10);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gateCnt <= 0;
            headCnt <= 0;
            enCnt <= 0;
            hostEnPrev <= 1'b0;
            enablePin <= 1'b0;
            gateAtLevel <= 1'b0;
            ledHeadroomOk <= 1'b0;
            ledAboveDetect <= 4'h0;
            ledShortGnd <= 4'h0;
            ledInUse <= 4'h0;
        end else begin
            hostEnPrev <= hostEn;
            // simplest host: every pulse is stretched to the first-pulse minimum
            if (hostEn && !hostEnPrev) begin
                enCnt <= FIRST_EN_MIN_CYC;
            end else if (enCnt > 0) begin
                enCnt <= enCnt - 1;
            end
            enablePin <= hostEn || (enCnt > 0);
            gateCnt <= disconnectDrive ? gateCnt + 1 : 0;
            gateAtLevel <= disconnectDrive && (gateCnt >= int'(gateDly));
            headCnt <= (sinkEnable != 4'h0) ? headCnt + 1 : 0;
            ledHeadroomOk <= (headCnt >= 30);
            for (int i = 0; i < 4; i++) begin
                ledShortGnd[i] <= pinUp && (chanCfg[2*i+:2] == 2'h0);
                ledAboveDetect[i] <= pinUp && (chanCfg[2*i+:2] != 2'h0);
                ledInUse[i] <= pinUp && (chanCfg[2*i+:2] == 2'h2);
            end
        end
    end
endmodule : lsfs_pin_model

// [tb/lsfs_sequencer_test.sv]
// self-checking bench of the start-up/fault sequencer
// assumes the pin model stands for board and host; overcurrent and enable counts shortened
`timescale 1ns/10ps
module lsfs_sequencer_test
    import lsfs_pkg::*;
;
    localparam int MOC = 20;
    localparam int ENL = 40;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic uvloRiseOk, uvloRunOk, freqSetSyncLow, senseTrip1, senseTrip2, hostEn;
    logic enablePin, gateAtLevel, ledHeadroomOk, disconnectDrive, softStartMode, switchLimitLow;
    logic [3:0] ledAboveDetect, ledShortGnd, ledInUse, sinkEnable, loopInclude, used;
    logic [7:0] chanCfg;
    logic [15:0] gateDly;
    int n_mismatch, comparisons, n, k;
    ////////////////////////////////////////////////////////////////////////////////
    lsfs_sequencer #(.MOD_OC_CYC(MOC), .ENLOW_CYC(ENL)) lsfs_sequencer_inst (.clk, .rstn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enablePin,
        .uvloRiseOk, .uvloRunOk, .freqSetSyncLow, .gateAtLevel, .ledAboveDetect,
        .ledShortGnd, .ledInUse, .ledHeadroomOk, .senseTrip1, .senseTrip2,
        .disconnectDrive, .sinkEnable, .loopInclude, .softStartMode, .switchLimitLow);
    lsfs_pin_model lsfs_pin_model_inst (.clk, .rstn, .hostEn, .chanCfg, .gateDly,
        .disconnectDrive, .sinkEnable, .enablePin, .gateAtLevel, .ledAboveDetect,
        .ledShortGnd, .ledInUse, .ledHeadroomOk);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge clk);
        end
        bound(i, 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, x);
        chk(nm, e, xe);
    endtask : rdchk
    // a w1c write clears the flag, so each check starts from a clean set
    task automatic evchk(input int b);
        apb(1'b0, EVENT_OFF, 32'h0);
        chk("event", rd[b], 1'b1);
        apb(1'b1, EVENT_OFF, 32'h0000000F);
        rdchk("event clear", EVENT_OFF, 32'h0, 1'b0);
    endtask : evchk
    task automatic wait_off();
        for (n = 0; n < 2000 && disconnectDrive === 1'b1; n++) begin
            @(posedge clk);
        end
        bound(n, 2000);
        chk("off sinks", {sinkEnable, loopInclude, softStartMode}, 9'h0);
    endtask : wait_off
    task automatic start_up(input logic [7:0] c);
        int i;
        for (i = 0; i < 4; i++) begin
            used[i] = (c[2*i+:2] == 2'h2);
        end
        chanCfg <= c;
        hostEn <= 1'b1;
        for (i = 0; i < 50 && disconnectDrive !== 1'b1; i++) begin
            @(posedge clk);
        end
        bound(i, 50);
        chk("sinks at gate", sinkEnable, 4'h0);
        for (i = 0; i < 2000 && !(gateAtLevel && &(ledAboveDetect | ledShortGnd)); i++) begin
            @(posedge clk);
        end
        bound(i, 2000);
        for (i = 0; i < 5000 && sinkEnable === 4'h0; i++) begin
            @(posedge clk);
        end
        bound(i, 5000);
        chk("detect wait", i >= DETECT_MIN_CYC && i <= DETECT_MAX_CYC + 10, 1'b1);
        chk("soft sinks", sinkEnable, used);
        chk("loop mask", loopInclude, used);
        chk("soft mode", {softStartMode, switchLimitLow}, 2'h3);
        for (i = 0; i < 200 && softStartMode === 1'b1; i++) begin
            @(posedge clk);
        end
        bound(i, 200);
        chk("run outputs", {sinkEnable, switchLimitLow}, {used, 1'b0});
    endtask : start_up
    function automatic logic [7:0] rnd_cfg();
        // channel 0 always in use so soft start has a sink to show
        return {2'($urandom_range(1, 2)), 2'($urandom_range(1, 2)), 2'($urandom_range(1, 2)),
            2'h2};
    endfunction : rnd_cfg
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, psel, penable, pwrite, freqSetSyncLow, senseTrip1, senseTrip2, hostEn} = 8'h0;
        {uvloRiseOk, uvloRunOk} = 2'h3;
        paddr = 12'h0;
        pwdata = 32'h0;
        chanCfg = 8'hAA;
        gateDly = 16'h0005;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(56));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk("ctrl", CTRL_OFF, CTRL_RST, 1'b0);
        rdchk("status", STATUS_OFF, 32'h00000001, 1'b0);
        rdchk("events", EVENT_OFF, 32'(EVENT_RST), 1'b0);
        rdchk("unmapped", 12'h00C, 32'h0, 1'b1);
        apb(1'b1, STATUS_OFF, 32'hFFFFFFFF);
        rdchk("status ro", STATUS_OFF, 32'h00000001, 1'b0);
        for (k = 0; k < 3; k++) begin
            uvloRiseOk <= (k != 0);
            freqSetSyncLow <= (k == 1);
            apb(1'b1, CTRL_OFF, {31'h0, k != 2});
            hostEn <= 1'b1;
            repeat (30) @(posedge clk);
            chk("blocked start", disconnectDrive, 1'b0);
            hostEn <= 1'b0;
            @(posedge clk);
        end
        uvloRiseOk <= 1'b1;
        freqSetSyncLow <= 1'b0;
        apb(1'b1, CTRL_OFF, 32'h00000001);
        gateDly <= 16'h0258;
        start_up(rnd_cfg());
        hostEn <= 1'b0;
        repeat (10) @(posedge clk);
        chk("dimmed", {disconnectDrive, sinkEnable}, 5'h10);
        hostEn <= 1'b1;
        uvloRiseOk <= 1'b0;
        repeat (50) @(posedge clk);
        rdchk("run on low supply", STATUS_OFF, {20'h0, used, 8'h20}, 1'b0);
        uvloRunOk <= 1'b0;
        wait_off();
        chk("supply drop", n <= 10, 1'b1);
        hostEn <= 1'b0;
        evchk(EV_UV_DROP);
        {uvloRiseOk, uvloRunOk} <= 2'h3;
        gateDly <= 16'h0005;
        start_up(rnd_cfg());
        for (k = 0; k < 3; k++) begin
            senseTrip1 <= 1'b1;
            repeat ($urandom_range(2, MOC - 4)) @(posedge clk);
            senseTrip1 <= 1'b0;
            repeat (3) @(posedge clk);
        end
        chk("short trip", disconnectDrive, 1'b1);
        senseTrip1 <= 1'b1;
        hostEn <= 1'b0;
        wait_off();
        chk("moderate oc", n >= MOC && n <= MOC + 8, 1'b1);
        rdchk("idle after oc", STATUS_OFF, 32'h00000001, 1'b0);
        senseTrip1 <= 1'b0;
        evchk(EV_MOD_OC);
        start_up(rnd_cfg());
        {senseTrip1, senseTrip2} <= 2'h3;
        hostEn <= 1'b0;
        wait_off();
        chk("severe oc", n <= SEVERE_OC_MAX_CYC, 1'b1);
        {senseTrip1, senseTrip2} <= 2'h0;
        evchk(EV_SEV_OC);
        start_up(rnd_cfg());
        hostEn <= 1'b0;
        wait_off();
        chk("enable low", n >= ENL && n <= ENL + 8, 1'b1);
        evchk(EV_EN_LOW);
        chanCfg <= 8'hA8;
        hostEn <= 1'b1;
        repeat (4500) @(posedge clk);
        chk("short hold", sinkEnable, 4'h0);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("short state", {rd[15:12], rd[5:0]}, {4'h1, 6'(S_SHORT)});
        start_up(8'hAA);
        end_of_test();
    end
endmodule : lsfs_sequencer_test
